// ===== src/mod_pkg.sv
/*
 Shared constants for the minicomputer opcode decoder: APB register offsets,
 flag bit positions, operation classes and execution times.
 Assumes a 250 MHz processor clock; times are kept in nanoseconds.
*/
package mod_pkg;

    // ------------------------------------------------------------
    // Clock and register map.
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam logic [11:0] OFF_INSTR  = 12'h000; // Instruction word to decode.
    localparam logic [11:0] OFF_FLAGS  = 12'h004; // Condition inputs for skips.
    localparam logic [11:0] OFF_RESULT = 12'h008; // Decoded class and skip.
    localparam logic [11:0] OFF_CYCLES = 12'h00c; // Selected time in cycles.
    localparam logic [11:0] OFF_STATUS = 12'h010; // Protect state, counter.
    localparam logic [11:0] OFF_MSEQ   = 12'h014; // Micro-sequence extra cycles.

    // ------------------------------------------------------------
    // Flag register bit positions.
    // ------------------------------------------------------------
    localparam int unsigned FLG_SWITCH = 0; // Console switch set.
    localparam int unsigned FLG_PARITY = 1; // Storage parity error flagged.
    localparam int unsigned FLG_EQUAL  = 2; // Compare operands match.
    localparam int unsigned FLG_REGZ   = 3; // Tested register is zero.
    localparam int unsigned FLG_REGNEG = 4; // Tested register is negative.
    localparam int unsigned FLG_FIELDZ = 5; // Tested field is zero.
    localparam int unsigned FLG_MOVEXT = 6; // Register move long variant.
    localparam int unsigned FLG_DECEXT = 7; // Decrement-repeat long variant.
    localparam logic [31:0] FLAGS_RST  = 32'h0000_0000;

    // ------------------------------------------------------------
    // Operation classes reported in the result register.
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NONE, OP_SKIP_SWITCH_CLEAR, OP_SKIP_NO_PARITY_FAULT, OP_SKIP_PARITY_FAULT,
        OP_SKIP_PROTECT_FAULT, OP_SKIP_NO_PROTECT_FAULT, OP_PROTECT_CLEAR,
        OP_PROTECT_SET, OP_POSITION_STATUS_SAMPLE, OP_MICRO_INTERRUPT_DEFINE,
        OP_REGISTER_SET_STORE, OP_USER_MICROSEQUENCE_START, OP_UPPER_BOUND_LOAD,
        OP_REG_TEST_ZERO, OP_REG_TEST_NEG, OP_REG_TEST_NONZERO, OP_REG_TEST_POS,
        OP_DECREMENT_REPEAT, OP_REGISTER_MOVE, OP_STORE_WITH_PARITY,
        OP_FIELD_NONZERO_SKIP, OP_FIELD_ZERO_SKIP, OP_FIELD_FILL_ONES,
        OP_FIELD_ZERO_FILL, OP_MEMORY_INCREMENT, OP_XOR_TO_ALL, OP_INTER_REG,
        OP_COMPARE
    } mod_op_t;

    // ------------------------------------------------------------
    // Execution times in nanoseconds and their cycle counts.
    // ------------------------------------------------------------
    localparam int unsigned T_NOP_NS        = 1170;
    localparam int unsigned T_SWITCH_NS [2] = '{1120, 1400};
    localparam int unsigned T_PARITY_NS [2] = '{1350, 1460};
    localparam int unsigned T_PROTECT_NS[2] = '{1170, 1460};
    localparam int unsigned T_REGTEST_NS[2] = '{1910, 2020};
    localparam int unsigned T_FIELD_NS  [2] = '{5850, 6080};
    localparam int unsigned T_CMP_NS    [2] = '{5230, 5460};
    localparam int unsigned T_PROT_OP_NS    = 1720;
    localparam int unsigned T_SPS_NS        = 3940;
    localparam int unsigned T_DMI_NS        = 3430;
    localparam int unsigned T_SRG_NS        = 12590;
    localparam int unsigned T_EMS_NS        = 6200;
    localparam int unsigned T_LUB_NS        = 2140;
    localparam int unsigned T_DRP_NS        = 2220;
    localparam int unsigned T_DRP_EXT_NS    = 620;
    localparam int unsigned T_XFR_NS        = 2470;
    localparam int unsigned T_XFR_EXT_NS    = 670;
    localparam int unsigned T_SPA_NS        = 2180;
    localparam int unsigned T_FILL_NS       = 6640;
    localparam int unsigned T_RAO_NS        = 2220;
    localparam int unsigned T_XOR_NS    [4] = '{1630, 1800, 1960, 2130};

    // Converts a time to whole cycles, rounding up, never below one cycle.
    function automatic logic [15:0] ns2cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c == 0)
            c = 1;
        return c[15:0];
    endfunction

    // Execution-time unit state, one packed struct per module.
    typedef struct packed {
        logic [15:0] instr;
        logic [31:0] flags;
        logic [15:0] mseq;
        mod_op_t     op;
        logic        skip;
        logic [3:0]  skip_cnt;
        logic [1:0]  dest;
        logic [15:0] cycles;
        logic        prot;
        logic [15:0] decode_cnt;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } mod_state_t;

endpackage

// ===== src/mod_time_rom.sv
/*
 Registered lookup of execution-time cycle counts per operation class.
 Assumes the caller presents the class, variant and extra overhead one cycle
 ahead of when the count is needed.
*/
`timescale 1ns/1ps
module mod_time_rom
    import mod_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Lookup request.
    input  wire mod_op_t     op,
    input  wire logic [1:0]  variant,
    input  wire logic [15:0] extra,
    // Registered count.
    output logic      [15:0] cycles
);

    // ------------------------------------------------------------
    // Registered read keeps the long adder chain off the decode path.
    // ------------------------------------------------------------
    logic [15:0] base;

    // Picks the base count; variant bit 0 selects the long time of a pair.
    always_comb
    begin
        case (op)
            OP_SKIP_SWITCH_CLEAR:       base = ns2cyc(T_SWITCH_NS[variant[0]]);
            OP_SKIP_NO_PARITY_FAULT,
            OP_SKIP_PARITY_FAULT:       base = ns2cyc(T_PARITY_NS[variant[0]]);
            OP_SKIP_PROTECT_FAULT,
            OP_SKIP_NO_PROTECT_FAULT:   base = ns2cyc(T_PROTECT_NS[variant[0]]);
            OP_REG_TEST_ZERO, OP_REG_TEST_NEG,
            OP_REG_TEST_NONZERO, OP_REG_TEST_POS:
                                        base = ns2cyc(T_REGTEST_NS[variant[0]]);
            OP_FIELD_NONZERO_SKIP,
            OP_FIELD_ZERO_SKIP:         base = ns2cyc(T_FIELD_NS[variant[0]]);
            OP_COMPARE:                 base = ns2cyc(T_CMP_NS[variant[0]]);
            OP_XOR_TO_ALL:              base = ns2cyc(T_XOR_NS[variant]);
            OP_PROTECT_CLEAR,
            OP_PROTECT_SET:             base = ns2cyc(T_PROT_OP_NS);
            OP_POSITION_STATUS_SAMPLE:  base = ns2cyc(T_SPS_NS);
            OP_MICRO_INTERRUPT_DEFINE:  base = ns2cyc(T_DMI_NS);
            OP_REGISTER_SET_STORE:      base = ns2cyc(T_SRG_NS);
            OP_USER_MICROSEQUENCE_START: base = ns2cyc(T_EMS_NS);
            OP_UPPER_BOUND_LOAD:        base = ns2cyc(T_LUB_NS);
            OP_DECREMENT_REPEAT:        base = variant[0] ? ns2cyc(T_DRP_NS + T_DRP_EXT_NS)
                                                          : ns2cyc(T_DRP_NS);
            OP_REGISTER_MOVE:           base = variant[0] ? ns2cyc(T_XFR_NS + T_XFR_EXT_NS)
                                                          : ns2cyc(T_XFR_NS);
            OP_STORE_WITH_PARITY:       base = ns2cyc(T_SPA_NS);
            OP_FIELD_FILL_ONES,
            OP_FIELD_ZERO_FILL:         base = ns2cyc(T_FILL_NS);
            OP_MEMORY_INCREMENT:        base = ns2cyc(T_RAO_NS);
            default:                    base = ns2cyc(T_NOP_NS);
        endcase
    end

    // Registers the count; the micro-sequence overhead is added here.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cycles <= 16'h0000;
        else
            cycles <= base + extra;
    end

endmodule

// ===== src/mod_decode.sv
/*
 Instruction decoder and execution-time selector for a 16-bit microprogrammed
 minicomputer, reached over APB. Assumes synchronous APB master on pclk.
*/
// The APB register port and the register offsets were left to the implementer.
// Contract
// - Skips: short time unskipped, long when taken.
// - Compare: first time unequal, second time equal; no compare word is decoded, OP_COMPARE is never selected.
// - Inter-register time by destination set, four; only XOR-to-all is decoded, always with the fourth time.
// - 0,1,9,n skips on switch clear, n count.
// - 0,1,D skip no parity; C skip parity.
// - 0,1,E skip protect fault; B no fault.
// - 0700 clears protect, 0600 sets protect.
// - 0,B,x,5/6/3: status, micro interrupt, store set; decoded only with x = 0.
// - 0,B,r,2 starts micro-sequence, overhead plus duration.
// - 0,B,r,0 loads upper unprotected bound.
// - 0,0,t,n: register test zero/neg/nonzero/pos.
// - 0,6,even nonzero: decrement-repeat, optional extra.
// - 0,7,0-7,1-7: register move, optional extra.
// - Major 7: store with parity to accumulator.
// - 0,5,x,3/B field nonzero; 2/A zero skip.
// - Major D: memory increment in place.
// - 0,8,7,8-F: exclusive-OR to A, Q, M.
`timescale 1ns/1ps
module mod_decode
    import mod_pkg::*;
(
    // APB clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB request.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    // APB answer.
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Decode result toward the microsequencer.
    output logic             protect_q,
    output logic             skip_q,
    output logic      [15:0] cycles_q
);

    // ------------------------------------------------------------
    // State and digit fields.
    // ------------------------------------------------------------
    mod_state_t  s_q;          // All registered state.
    mod_state_t  s_d;          // Next state.
    logic [3:0]  f_major;      // Major function digit.
    logic [3:0]  f_sub;        // Sub-function digit.
    logic [3:0]  f_third;      // Third digit.
    logic [3:0]  f_low;        // Low digit or displacement.
    logic        setup;        // Setup phase of an APB transfer.
    logic        wr_en;        // Write takes effect this edge.
    logic        rd_en;        // Read data taken this edge.
    logic        hit;          // Address maps to a register.
    mod_op_t     dec_op;       // Combinational decode class.
    logic        dec_skip;     // Combinational skip outcome.
    logic [1:0]  dec_var;      // Time variant selector.
    logic [15:0] rom_cycles;   // Registered count from the lookup.

    assign f_major = s_q.instr[15:12];
    assign f_sub   = s_q.instr[11:8];
    assign f_third = s_q.instr[7:4];
    assign f_low   = s_q.instr[3:0];

    // ------------------------------------------------------------
    // Decode of the held instruction word.
    // ------------------------------------------------------------
    // Every unlisted word falls through to the no-operation class.
    always_comb
    begin
        dec_op   = OP_NONE;
        dec_skip = 1'b0;
        dec_var  = 2'b00;
        case (f_major)
            4'h0:
            begin
                case (f_sub)
                    4'h0:
                    begin
                        // Low two bits of the third digit name the test type.
                        case (f_third[1:0])
                            2'b00:
                            begin
                                dec_op   = OP_REG_TEST_ZERO;
                                dec_skip = s_q.flags[FLG_REGZ];
                            end
                            2'b01:
                            begin
                                dec_op   = OP_REG_TEST_NONZERO;
                                dec_skip = !s_q.flags[FLG_REGZ];
                            end
                            2'b10:
                            begin
                                dec_op   = OP_REG_TEST_POS;
                                dec_skip = !s_q.flags[FLG_REGNEG];
                            end
                            default:
                            begin
                                dec_op   = OP_REG_TEST_NEG;
                                dec_skip = s_q.flags[FLG_REGNEG];
                            end
                        endcase
                    end
                    4'h1:
                    begin
                        case (f_third)
                            4'h9:
                            begin
                                dec_op   = OP_SKIP_SWITCH_CLEAR;
                                dec_skip = !s_q.flags[FLG_SWITCH];
                            end
                            4'hd:
                            begin
                                dec_op   = OP_SKIP_NO_PARITY_FAULT;
                                dec_skip = !s_q.flags[FLG_PARITY];
                            end
                            4'hc:
                            begin
                                dec_op   = OP_SKIP_PARITY_FAULT;
                                dec_skip = s_q.flags[FLG_PARITY];
                            end
                            4'he:
                            begin
                                dec_op   = OP_SKIP_PROTECT_FAULT;
                                dec_skip = s_q.prot;
                            end
                            4'hb:
                            begin
                                dec_op   = OP_SKIP_NO_PROTECT_FAULT;
                                dec_skip = !s_q.prot;
                            end
                            default:
                                dec_op   = OP_NONE;
                        endcase
                    end
                    4'h5:
                    begin
                        case (f_low)
                            4'h3, 4'hb:
                            begin
                                dec_op   = OP_FIELD_NONZERO_SKIP;
                                dec_skip = !s_q.flags[FLG_FIELDZ];
                            end
                            4'h2, 4'ha:
                            begin
                                dec_op   = OP_FIELD_ZERO_SKIP;
                                dec_skip = s_q.flags[FLG_FIELDZ];
                            end
                            4'h7, 4'hf: dec_op = OP_FIELD_FILL_ONES;
                            4'h6:       dec_op = OP_FIELD_ZERO_FILL;
                            default:    dec_op = OP_NONE;
                        endcase
                    end
                    4'h6:
                    begin
                        if (s_q.instr[7:0] == 8'h00)
                            dec_op = OP_PROTECT_SET;
                        else if (!f_third[0] && f_third != 4'h0)
                        begin
                            dec_op  = OP_DECREMENT_REPEAT;
                            dec_var = {1'b0, s_q.flags[FLG_DECEXT]};
                        end
                    end
                    4'h7:
                    begin
                        if (s_q.instr[7:0] == 8'h00)
                            dec_op = OP_PROTECT_CLEAR;
                        else if (!f_third[3] && f_low != 4'h0 && !f_low[3])
                        begin
                            dec_op  = OP_REGISTER_MOVE;
                            dec_var = {1'b0, s_q.flags[FLG_MOVEXT]};
                        end
                    end
                    4'h8:
                    begin
                        if (f_third == 4'h7 && f_low[3])
                        begin
                            dec_op  = OP_XOR_TO_ALL;
                            dec_var = 2'b11;
                        end
                    end
                    4'hb:
                    begin
                        case (f_low)
                            4'h5: dec_op = (f_third == 4'h0) ? OP_POSITION_STATUS_SAMPLE
                                                             : OP_NONE;
                            4'h6: dec_op = (f_third == 4'h0) ? OP_MICRO_INTERRUPT_DEFINE
                                                             : OP_NONE;
                            4'h3: dec_op = (f_third == 4'h0) ? OP_REGISTER_SET_STORE
                                                             : OP_NONE;
                            4'h2: dec_op = OP_USER_MICROSEQUENCE_START;
                            4'h0: dec_op = OP_UPPER_BOUND_LOAD;
                            default: dec_op = OP_NONE;
                        endcase
                    end
                    default:
                        dec_op = OP_NONE;
                endcase
            end
            4'h7: dec_op = OP_STORE_WITH_PARITY;
            4'hd: dec_op = OP_MEMORY_INCREMENT;
            default:
                dec_op = OP_NONE;
        endcase
        // Skip-type classes take their long time only when the skip is taken.
        if (dec_op != OP_DECREMENT_REPEAT && dec_op != OP_REGISTER_MOVE
            && dec_op != OP_XOR_TO_ALL)
            dec_var = {1'b0, dec_skip};
    end

    // ------------------------------------------------------------
    // Execution-time lookup.
    // ------------------------------------------------------------
    mod_time_rom u_rom
    (
        .pclk    (pclk),
        .presetn (presetn),
        .op      (dec_op),
        .variant (dec_var),
        .extra   ((dec_op == OP_USER_MICROSEQUENCE_START) ? s_q.mseq : 16'h0000),
        .cycles  (rom_cycles)
    );

    // ------------------------------------------------------------
    // APB slave and state update.
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = setup && !pwrite;
    assign hit   = (paddr == OFF_INSTR) || (paddr == OFF_FLAGS) || (paddr == OFF_RESULT)
                || (paddr == OFF_CYCLES) || (paddr == OFF_STATUS) || (paddr == OFF_MSEQ);

    // The slave answers one cycle after setup, so pready is a registered
    // flag raised in setup; reads are captured then to keep prdata a flop.
    always_comb
    begin
        s_d          = s_q;
        s_d.pready   = setup;
        s_d.pslverr  = setup && !hit;
        s_d.op       = dec_op;
        s_d.skip     = dec_skip;
        s_d.skip_cnt = f_low;
        s_d.dest     = dec_var;
        s_d.cycles   = rom_cycles;
        // Protect state follows the held set and clear words.
        if (dec_op == OP_PROTECT_CLEAR)
            s_d.prot = 1'b0;
        else if (dec_op == OP_PROTECT_SET)
            s_d.prot = 1'b1;
        if (wr_en)
        begin
            case (paddr)
                OFF_INSTR:
                begin
                    s_d.instr      = pwdata[15:0];
                    s_d.decode_cnt = s_q.decode_cnt + 16'h0001;
                end
                OFF_FLAGS: s_d.flags = pwdata;
                OFF_MSEQ:  s_d.mseq  = pwdata[15:0];
                default:   s_d.flags = s_q.flags;
            endcase
        end
        if (rd_en)
        begin
            case (paddr)
                OFF_INSTR:  s_d.prdata = {16'h0000, s_q.instr};
                OFF_FLAGS:  s_d.prdata = s_q.flags;
                OFF_RESULT: s_d.prdata = {18'h00000, s_q.dest, s_q.skip_cnt,
                                          s_q.skip, 2'b00, s_q.op};
                OFF_CYCLES: s_d.prdata = {16'h0000, s_q.cycles};
                OFF_STATUS: s_d.prdata = {s_q.decode_cnt, 15'h0000, s_q.prot};
                OFF_MSEQ:   s_d.prdata = {16'h0000, s_q.mseq};
                default:    s_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    // Registers the whole state; reset clears the word to 0000, a register-test-zero word.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q        <= '0;
            s_q.flags  <= FLAGS_RST;
            s_q.op     <= OP_NONE;
        end
        else
            s_q <= s_d;
    end

    assign prdata    = s_q.prdata;
    assign pready    = s_q.pready;
    assign pslverr   = s_q.pslverr;
    assign protect_q = s_q.prot;
    assign skip_q    = s_q.skip;
    assign cycles_q  = s_q.cycles;

endmodule

// ===== bench/mod_decode_assertions.sv
/* Port checker for the opcode decoder; bound to mod_decode, APB on pclk. */
`timescale 1ns/1ps
module mod_decode_chk
    import mod_pkg::*;
(
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic        protect_q, skip_q,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [15:0] cycles_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed instruction write; decode starts from this edge.
    logic wr;
    assign wr = psel && penable && pready && pwrite && paddr == OFF_INSTR;
    property p_rdy; pready |=> !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready held");
    property p_err; psel && !penable && paddr > OFF_MSEQ |=> pready && pslverr; endproperty
    a_err: assert property (p_err) else $error("no slave error");
    property p_set; wr && pwdata[15:0] == 16'h0600 |-> ##2 protect_q; endproperty
    a_set: assert property (p_set) else $error("protect not set");
    property p_clr; wr && pwdata[15:0] == 16'h0700 |-> ##2 !protect_q; endproperty
    a_clr: assert property (p_clr) else $error("protect not clear");
    property p_swn; wr && pwdata[15:4] == 12'h019 |-> ##3 cycles_q == (skip_q ? 16'd350 : 16'd280); endproperty
    a_swn: assert property (p_swn) else $error("skip time");
    property p_xor; wr && pwdata[15:0] == 16'h0878 |-> ##3 cycles_q == 16'd533; endproperty
    a_xor: assert property (p_xor) else $error("xor time");
    property p_inc; wr && pwdata[15:12] == 4'hd |-> ##3 cycles_q == 16'd555; endproperty
    a_inc: assert property (p_inc) else $error("increment time");
    property p_spa; wr && pwdata[15:12] == 4'h7 |-> ##3 cycles_q == 16'd545; endproperty
    a_spa: assert property (p_spa) else $error("store time");
    property p_nop; wr && pwdata[15:12] == 4'h1 |-> ##3 cycles_q == 16'd293; endproperty
    a_nop: assert property (p_nop) else $error("nop time");
endmodule
bind mod_decode mod_decode_chk u_chk (.*);

// ===== bench/mod_useq_model.sv
/* Microsequencer stand-in: latches each new execution time it is handed. */
`timescale 1ns/1ps
module mod_useq_model (
    // Clock.
    input  wire logic        pclk,
    // Time handed over by the decoder.
    input  wire logic [15:0] cycles_q,
    // Time the sequencer is running now.
    output logic      [15:0] run_q
);
    // Holds the last time seen one edge later; the decoder never waits on it.
    always @(posedge pclk)
        run_q <= cycles_q;
endmodule

// ===== bench/mod_decode_tb_top.sv
/* Self-checking bench for mod_decode over APB, 250 MHz clock. */
`timescale 1ns/1ps
module mod_decode_tb_top;
    import mod_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, protect_q, skip_q, er;
    logic [15:0] cycles_q, run_q, want;
    int          n_mismatch = 0, cmp_count = 0;
    // Words, flags, expected skip, protect and time in ns.
    // Bit i of sk and pr belongs to entry i.
    logic [15:0] ins [22] = '{16'h0195, 16'h0195, 16'h01d0, 16'h01c0, 16'h0878, 16'h1000,
                              16'hd123, 16'h7000, 16'h0600, 16'h01e0, 16'h0700, 16'h01b0,
                              16'h0010, 16'h0030, 16'h0543, 16'h0517, 16'h0625, 16'h0712,
                              16'h0b05, 16'h0b42, 16'h0b40, 16'h0605};
    logic [31:0] flg [22] = '{0, 1, 2, 2, 0, 0, 0, 0, 0, 0, 0, 0,
                              8, 16, 32, 0, 128, 64, 0, 0, 0, 0};
    logic [21:0] sk = 22'h02a09, pr = 22'h00300;
    int ns [22] = '{T_SWITCH_NS[1], T_SWITCH_NS[0], T_PARITY_NS[0], T_PARITY_NS[1],
                    T_XOR_NS[3], T_NOP_NS, T_RAO_NS, T_SPA_NS, T_PROT_OP_NS,
                    T_PROTECT_NS[1], T_PROT_OP_NS, T_PROTECT_NS[1],
                    T_REGTEST_NS[0], T_REGTEST_NS[1], T_FIELD_NS[0], T_FILL_NS,
                    T_DRP_NS + T_DRP_EXT_NS, T_XFR_NS + T_XFR_EXT_NS, T_SPS_NS,
                    T_EMS_NS + 16 * CLK_PERIOD_NS, T_LUB_NS, T_NOP_NS};
    always #2 pclk = ~pclk;
    mod_decode dut (.*);
    mod_useq_model u_seq (.*);
    task automatic test_done;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer, entered just after a rising edge; ends one edge after the access edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            test_done;
        end
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, OFF_STATUS, 0);
        chk(rd, 0);
        apb(0, 12'h020, 0);
        chk({rd[30:0], er}, 1);
        apb(1, OFF_MSEQ, 32'h0000_0010);
        for (int i = 0; i < 22; i++)
        begin
            apb(1, OFF_FLAGS, flg[i]);
            apb(1, OFF_INSTR, {16'h0, ins[i]});
            // The time settles two edges after the write; look at the edge after that.
            repeat (2) @(posedge pclk);
            want = 16'((ns[i] + 3) / 4);
            chk({skip_q, protect_q, cycles_q}, {sk[i], pr[i], want});
            @(posedge pclk);
            chk(run_q, want);
        end
        apb(0, OFF_RESULT, 0);
        chk(rd, 32'h0000_0500);
        apb(0, OFF_STATUS, 0);
        chk(rd, 32'h0016_0000);
        test_done;
    end
endmodule
